// ===== dwc_map.svh
// offsets, fields, reset values and codes of the watch channel
//
// Notes on behaviour
// - enabled channel runs until field changed
// - armed code becomes 1111 after event
// - one cycle enable latency, first pc skipped
// - address codes 0001-1010 arm on listed events, data codes 0001-1001
// - address 1011 arms on pin, 1100 holds; data 1010 arms on pin, 1011 holds
// - 1101/1110 reserved (data also 1100), 1111 always enabled
// - combine comparators: a, b, and, or
// - comparator b condition: eq ne gt lt
// - comparator a condition: eq ne gt lt
// - access kind: read, write, either
// - bus select: a, b, both, pc
// - ignore low address bits by width
// - detection sets per-channel hit flag
// - three writable 32-bit reference registers
// - address anded with mask before compare
// - data width select byte word long
// - byte mode: one or four lanes ored
// - word mode: one, two, four lanes
// - long mode: one or two lanes
// - data mask applied to both halves
`ifndef DWC_MAP_SVH
`define DWC_MAP_SVH

`define DWC_OFS_ADDR_CTRL   8'h00
`define DWC_OFS_REF_A       8'h04
`define DWC_OFS_REF_B       8'h08
`define DWC_OFS_ADDR_MASK   8'h0c
`define DWC_OFS_DATA_CTRL   8'h10
`define DWC_OFS_DATA_REF    8'h14
`define DWC_OFS_DATA_MASK   8'h18
`define DWC_OFS_STATUS      8'h1c

`define DWC_CTRL_RESET      16'h0000
`define DWC_MASK_RESET      32'hffffffff
`define DWC_REF_RESET       32'h00000000

`define DWC_A_EN_HI         13
`define DWC_A_EN_LO         10
`define DWC_A_CS_HI         9
`define DWC_A_CS_LO         8
`define DWC_A_CB_HI         7
`define DWC_A_CB_LO         6
`define DWC_A_CA_HI         5
`define DWC_A_CA_LO         4
`define DWC_A_ATS_HI        3
`define DWC_A_ATS_LO        2
`define DWC_A_BS_HI         1
`define DWC_A_BS_LO         0
`define DWC_A_WR_MASK       16'h3fff

`define DWC_D_AWS_HI        9
`define DWC_D_AWS_LO        8
`define DWC_D_EN_HI         6
`define DWC_D_EN_LO         3
`define DWC_D_CC_HI         2
`define DWC_D_CC_LO         1
`define DWC_D_ATS           0
`define DWC_D_WR_MASK       16'h037f

`define DWC_ST_ADDR_HIT     0
`define DWC_ST_DATA_HIT     1

`define DWC_EN_OFF          4'h0
`define DWC_EN_EV_LAST      4'h8
`define DWC_EN_ON           4'hf
`define DWC_A_EN_DATA       4'h9
`define DWC_A_EN_COUNT      4'ha
`define DWC_A_EN_PIN        4'hb
`define DWC_A_EN_PIN_HOLD   4'hc
`define DWC_D_EN_COUNT      4'h9
`define DWC_D_EN_PIN        4'ha
`define DWC_D_EN_PIN_HOLD   4'hb

`endif

// ===== dwc_pkg.sv
// types of the watch channel
package dwc_pkg;
  typedef enum logic [1:0] {
    DWC_COND_EQ = 2'h0,
    DWC_COND_NE = 2'h1,
    DWC_COND_GT = 2'h2,
    DWC_COND_LT = 2'h3
  } dwc_cond_t;
  typedef enum logic [1:0] {
    DWC_COMB_A   = 2'h0,
    DWC_COMB_B   = 2'h1,
    DWC_COMB_AND = 2'h2,
    DWC_COMB_OR  = 2'h3
  } dwc_comb_t;
  typedef enum logic [1:0] {
    DWC_BUS_A    = 2'h0,
    DWC_BUS_B    = 2'h1,
    DWC_BUS_BOTH = 2'h2,
    DWC_BUS_PC   = 2'h3
  } dwc_bus_t;
  typedef enum logic [1:0] {
    DWC_ACC_RD  = 2'h0,
    DWC_ACC_WR  = 2'h1,
    DWC_ACC_ANY = 2'h2,
    DWC_ACC_RSV = 2'h3
  } dwc_acc_t;
  // access width on an address bus
  typedef enum logic [1:0] {
    DWC_AW_8  = 2'h0,
    DWC_AW_16 = 2'h1,
    DWC_AW_32 = 2'h2,
    DWC_AW_64 = 2'h3
  } dwc_aw_t;
  // watched data width
  typedef enum logic [1:0] {
    DWC_DW_BYTE = 2'h0,
    DWC_DW_WORD = 2'h1,
    DWC_DW_LONG = 2'h2,
    DWC_DW_RSV  = 2'h3
  } dwc_dw_t;
  // operands in one data access
  typedef enum logic [1:0] {
    DWC_OPS_1 = 2'h0,
    DWC_OPS_2 = 2'h1,
    DWC_OPS_4 = 2'h2,
    DWC_OPS_X = 2'h3
  } dwc_ops_t;
endpackage

// ===== dwc_watch.sv
// address and data watch channel with its control registers
`timescale 1ns/1ps
`include "dwc_map.svh"
module dwc_watch (
  input  wire logic            clk_in,
  input  wire logic            rst_n_in,
  input  wire logic [7:0]      reg_addr_in,
  input  wire logic [31:0]     reg_wdata_in,
  input  wire logic            reg_wr_in,
  input  wire logic            reg_rd_in,
  output logic      [31:0]     reg_rdata_out,
  input  wire logic [31:0]     pc_in,
  input  wire logic            pc_valid_in,
  input  wire logic [31:0]     data_address_bus_a_in,
  input  wire logic            bus_a_valid_in,
  input  wire logic            bus_a_write_in,
  input  wire dwc_pkg::dwc_aw_t bus_a_width_in,
  input  wire logic [31:0]     data_address_bus_b_in,
  input  wire logic            bus_b_valid_in,
  input  wire logic            bus_b_write_in,
  input  wire dwc_pkg::dwc_aw_t bus_b_width_in,
  input  wire logic [63:0]     data_value_in,
  input  wire logic            data_valid_in,
  input  wire logic            data_write_in,
  input  wire dwc_pkg::dwc_ops_t data_ops_in,
  input  wire logic [7:0]      channel_event_in,
  input  wire logic            count_event_in,
  input  wire logic            event_pin_in,
  input  wire logic            data_event_pin_in,
  input  wire logic            event_pin_config_in,
  input  wire logic            data_event_pin_config_in,
  output logic                 addr_event_out,
  output logic                 data_event_out,
  output logic                 channel_hit_flag_out,
  output logic                 data_hit_flag_out
);
  import dwc_pkg::*;

  logic [15:0] address_watch_control;
  logic [31:0] address_watch_reference_a;
  logic [31:0] address_watch_reference_b;
  logic [31:0] address_watch_mask;
  logic [15:0] data_watch_control;
  logic [31:0] data_reference;
  logic [31:0] data_mask;
  logic        pin_s1;
  logic        pin_s2;
  logic        dpin_s1;
  logic        dpin_s2;
  logic        addr_on_q;
  logic        addr_on_qq;
  logic        data_on_q;

  logic [3:0]  a_en;
  logic [3:0]  d_en;
  logic        pin_act;
  logic        dpin_act;
  logic        addr_match;
  logic        data_match;
  logic        wr_addr_ctrl;
  logic        wr_data_ctrl;
  logic        wr_status;

  assign a_en         = address_watch_control[`DWC_A_EN_HI:`DWC_A_EN_LO];
  assign d_en         = data_watch_control[`DWC_D_EN_HI:`DWC_D_EN_LO];
  assign pin_act      = pin_s2 & event_pin_config_in;
  assign dpin_act     = dpin_s2 & data_event_pin_config_in;
  assign wr_addr_ctrl = reg_wr_in && reg_addr_in == `DWC_OFS_ADDR_CTRL;
  assign wr_data_ctrl = reg_wr_in && reg_addr_in == `DWC_OFS_DATA_CTRL;
  assign wr_status    = reg_wr_in && reg_addr_in == `DWC_OFS_STATUS;

  function automatic logic cond_true(input logic [31:0] v, input logic [31:0] r,
    input dwc_cond_t c);
    logic res;
    res = 1'b0;
    unique case (c)
      DWC_COND_EQ: res = (v == r);
      DWC_COND_NE: res = (v != r);
      DWC_COND_GT: res = (v > r);
      DWC_COND_LT: res = (v < r);
    endcase
    return res;
  endfunction

  // low address bits that a wide access covers
  function automatic logic [31:0] width_mask(input dwc_aw_t w);
    logic [31:0] m;
    m = 32'hffffffff;
    unique case (w)
      DWC_AW_8:  m = 32'hffffffff;
      DWC_AW_16: m = 32'hfffffffe;
      DWC_AW_32: m = 32'hfffffffc;
      DWC_AW_64: m = 32'hfffffff8;
    endcase
    return m;
  endfunction

  function automatic logic kind_ok(input dwc_acc_t k, input logic wr);
    logic res;
    res = 1'b0;
    unique case (k)
      DWC_ACC_RD:  res = !wr;
      DWC_ACC_WR:  res = wr;
      DWC_ACC_ANY: res = 1'b1;
      DWC_ACC_RSV: res = 1'b0;
    endcase
    return res;
  endfunction

  // event pins are asynchronous
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_s1  <= 1'b0;
      pin_s2  <= 1'b0;
      dpin_s1 <= 1'b0;
      dpin_s2 <= 1'b0;
    end else begin
      pin_s1  <= event_pin_in;
      pin_s2  <= pin_s1;
      dpin_s1 <= data_event_pin_in;
      dpin_s2 <= dpin_s1;
    end
  end

  // reference, mask and data registers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      address_watch_reference_a <= `DWC_REF_RESET;
      address_watch_reference_b <= `DWC_REF_RESET;
      address_watch_mask        <= `DWC_MASK_RESET;
      data_reference            <= `DWC_REF_RESET;
      data_mask                 <= `DWC_MASK_RESET;
    end else if (reg_wr_in) begin
      if (reg_addr_in == `DWC_OFS_REF_A) begin
        address_watch_reference_a <= reg_wdata_in;
      end
      if (reg_addr_in == `DWC_OFS_REF_B) begin
        address_watch_reference_b <= reg_wdata_in;
      end
      if (reg_addr_in == `DWC_OFS_ADDR_MASK) begin
        address_watch_mask <= reg_wdata_in;
      end
      if (reg_addr_in == `DWC_OFS_DATA_REF) begin
        data_reference <= reg_wdata_in;
      end
      if (reg_addr_in == `DWC_OFS_DATA_MASK) begin
        data_mask <= reg_wdata_in;
      end
    end
  end

  // arming event of codes 0001 to 1010
  logic a_arm;
  always_comb begin
    a_arm = 1'b0;
    if (a_en >= 4'h1 && a_en <= `DWC_EN_EV_LAST) begin
      a_arm = channel_event_in[3'(a_en - 4'h1)];
    end else if (a_en == `DWC_A_EN_DATA) begin
      a_arm = data_match;
    end else if (a_en == `DWC_A_EN_COUNT) begin
      a_arm = count_event_in;
    end
  end

  // software write wins over rewrite
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      address_watch_control <= `DWC_CTRL_RESET;
    end else if (wr_addr_ctrl) begin
      address_watch_control <= reg_wdata_in[15:0] & `DWC_A_WR_MASK;
    end else if (a_arm) begin
      address_watch_control[`DWC_A_EN_HI:`DWC_A_EN_LO] <= `DWC_EN_ON;
    end else if (a_en == `DWC_A_EN_PIN && pin_act) begin
      address_watch_control[`DWC_A_EN_HI:`DWC_A_EN_LO] <= `DWC_A_EN_PIN_HOLD;
    end else if (a_en == `DWC_A_EN_PIN_HOLD && !pin_act) begin
      address_watch_control[`DWC_A_EN_HI:`DWC_A_EN_LO] <= `DWC_A_EN_PIN;
    end
  end

  // data channel arming event
  logic d_arm;
  always_comb begin
    d_arm = 1'b0;
    if (d_en >= 4'h1 && d_en <= `DWC_EN_EV_LAST) begin
      d_arm = channel_event_in[3'(d_en - 4'h1)];
    end else if (d_en == `DWC_D_EN_COUNT) begin
      d_arm = count_event_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_watch_control <= `DWC_CTRL_RESET;
    end else if (wr_data_ctrl) begin
      data_watch_control <= reg_wdata_in[15:0] & `DWC_D_WR_MASK;
    end else if (d_arm) begin
      data_watch_control[`DWC_D_EN_HI:`DWC_D_EN_LO] <= `DWC_EN_ON;
    end else if (d_en == `DWC_D_EN_PIN && dpin_act) begin
      data_watch_control[`DWC_D_EN_HI:`DWC_D_EN_LO] <= `DWC_D_EN_PIN_HOLD;
    end else if (d_en == `DWC_D_EN_PIN_HOLD && !dpin_act) begin
      data_watch_control[`DWC_D_EN_HI:`DWC_D_EN_LO] <= `DWC_D_EN_PIN;
    end
  end

  // one cycle enable latency; reserved codes stay off
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_on_q  <= 1'b0;
      addr_on_qq <= 1'b0;
      data_on_q  <= 1'b0;
    end else begin
      addr_on_q  <= (a_en == `DWC_EN_ON) || (a_en == `DWC_A_EN_PIN_HOLD);
      addr_on_qq <= addr_on_q;
      data_on_q  <= (d_en == `DWC_EN_ON) || (d_en == `DWC_D_EN_PIN_HOLD);
    end
  end

  // address comparators
  dwc_bus_t  bs;
  dwc_comb_t cs;
  dwc_acc_t  access_kind_select;
  logic [31:0] addr_sel_a;
  logic [31:0] addr_sel_b;
  logic [31:0] wmask_a;
  logic [31:0] wmask_b;
  logic        val_a;
  logic        val_b;
  logic        hit_a;
  logic        hit_b;
  logic [31:0] cmp_mask_a;
  logic [31:0] cmp_mask_b;

  assign bs  = dwc_bus_t'(address_watch_control[`DWC_A_BS_HI:`DWC_A_BS_LO]);
  assign cs  = dwc_comb_t'(address_watch_control[`DWC_A_CS_HI:`DWC_A_CS_LO]);
  assign access_kind_select = dwc_acc_t'(address_watch_control[`DWC_A_ATS_HI:`DWC_A_ATS_LO]);

  always_comb begin
    addr_sel_a = data_address_bus_a_in;
    addr_sel_b = data_address_bus_b_in;
    wmask_a    = width_mask(bus_a_width_in);
    wmask_b    = width_mask(bus_b_width_in);
    val_a      = bus_a_valid_in & kind_ok(access_kind_select, bus_a_write_in);
    val_b      = bus_b_valid_in & kind_ok(access_kind_select, bus_b_write_in);
    unique case (bs)
      DWC_BUS_A: begin
        addr_sel_b = data_address_bus_a_in;
        wmask_b    = wmask_a;
        val_b      = val_a;
      end
      DWC_BUS_B: begin
        addr_sel_a = data_address_bus_b_in;
        wmask_a    = wmask_b;
        val_a      = val_b;
      end
      DWC_BUS_BOTH: begin
      end
      DWC_BUS_PC: begin
        addr_sel_a = pc_in;
        addr_sel_b = pc_in;
        wmask_a    = 32'hffffffff;
        wmask_b    = 32'hffffffff;
        val_a      = pc_valid_in & addr_on_qq;
        val_b      = val_a;
      end
    endcase
  end

  // masked and covered low bits always match
  assign cmp_mask_a = address_watch_mask & wmask_a;
  assign cmp_mask_b = address_watch_mask & wmask_b;
  assign hit_a = val_a & cond_true(addr_sel_a & cmp_mask_a,
    address_watch_reference_a & cmp_mask_a,
    dwc_cond_t'(address_watch_control[`DWC_A_CA_HI:`DWC_A_CA_LO])
    );
  assign hit_b = val_b & cond_true(addr_sel_b & cmp_mask_b,
    address_watch_reference_b & cmp_mask_b,
    dwc_cond_t'(address_watch_control[`DWC_A_CB_HI:`DWC_A_CB_LO])
    );

  always_comb begin
    addr_match = 1'b0;
    unique case (cs)
      DWC_COMB_A:   addr_match = hit_a;
      DWC_COMB_B:   addr_match = hit_b;
      DWC_COMB_AND: addr_match = hit_a & hit_b;
      DWC_COMB_OR:  addr_match = hit_a | hit_b;
    endcase
    addr_match = addr_match & addr_on_q;
  end

  // data comparators per lane
  logic [63:0] dmasked;
  logic [7:0]  b_eq;
  logic [7:0]  b_gt;
  logic [7:0]  b_lt;
  logic [3:0]  w_eq;
  logic [3:0]  w_gt;
  logic [3:0]  w_lt;
  logic [1:0]  l_eq;
  logic [1:0]  l_gt;
  logic [1:0]  l_lt;

  assign dmasked = data_value_in & {data_mask, data_mask};
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_lane
      assign b_eq[gi] = dmasked[8*gi +: 8] == data_reference[7:0];
      assign b_gt[gi] = dmasked[8*gi +: 8] >  data_reference[7:0];
      assign b_lt[gi] = dmasked[8*gi +: 8] <  data_reference[7:0];
      if (gi < 4) begin : g_word
        assign w_eq[gi] = dmasked[16*gi +: 16] == data_reference[15:0];
        assign w_gt[gi] = dmasked[16*gi +: 16] >  data_reference[15:0];
        assign w_lt[gi] = dmasked[16*gi +: 16] <  data_reference[15:0];
      end
      if (gi < 2) begin : g_long
        assign l_eq[gi] = dmasked[32*gi +: 32] == data_reference;
        assign l_gt[gi] = dmasked[32*gi +: 32] >  data_reference;
        assign l_lt[gi] = dmasked[32*gi +: 32] <  data_reference;
      end
    end
  endgenerate

  // operands from lane 0 up; not-equal needs all to differ
  logic [7:0] lane_en;
  logic [7:0] sel_eq;
  logic [7:0] sel_gt;
  logic [7:0] sel_lt;
  logic       cond_d;
  logic       width_ok;
  always_comb begin
    lane_en  = 8'h00;
    sel_eq   = 8'h00;
    sel_gt   = 8'h00;
    sel_lt   = 8'h00;
    width_ok = 1'b1;
    unique case (dwc_dw_t'(data_watch_control[`DWC_D_AWS_HI:`DWC_D_AWS_LO]))
      DWC_DW_BYTE: begin
        lane_en = (data_ops_in == DWC_OPS_1) ? 8'h01 : 8'h0f;
        sel_eq  = b_eq;
        sel_gt  = b_gt;
        sel_lt  = b_lt;
      end
      DWC_DW_WORD: begin
        lane_en = (data_ops_in == DWC_OPS_1) ? 8'h01 :
                  (data_ops_in == DWC_OPS_2) ? 8'h03 : 8'h0f;
        sel_eq  = {4'h0, w_eq};
        sel_gt  = {4'h0, w_gt};
        sel_lt  = {4'h0, w_lt};
      end
      DWC_DW_LONG: begin
        lane_en = (data_ops_in == DWC_OPS_1) ? 8'h01 : 8'h03;
        sel_eq  = {6'h00, l_eq};
        sel_gt  = {6'h00, l_gt};
        sel_lt  = {6'h00, l_lt};
      end
      DWC_DW_RSV: width_ok = 1'b0;
    endcase
    cond_d = 1'b0;
    unique case (dwc_cond_t'(data_watch_control[`DWC_D_CC_HI:`DWC_D_CC_LO]))
      DWC_COND_EQ: cond_d = |(sel_eq & lane_en);
      DWC_COND_NE: cond_d = ~|(sel_eq & lane_en);
      DWC_COND_GT: cond_d = |(sel_gt & lane_en);
      DWC_COND_LT: cond_d = |(sel_lt & lane_en);
    endcase
  end

  assign data_match = data_on_q & data_valid_in & width_ok & cond_d &
                      (data_write_in == data_watch_control[`DWC_D_ATS]);

  // sticky hit flags; a hit wins over a clear
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      addr_event_out       <= 1'b0;
      data_event_out       <= 1'b0;
      channel_hit_flag_out <= 1'b0;
      data_hit_flag_out    <= 1'b0;
    end else begin
      addr_event_out <= addr_match;
      data_event_out <= data_match;
      if (addr_match) begin
        channel_hit_flag_out <= 1'b1;
      end else if (wr_status && reg_wdata_in[`DWC_ST_ADDR_HIT]) begin
        channel_hit_flag_out <= 1'b0;
      end
      if (data_match) begin
        data_hit_flag_out <= 1'b1;
      end else if (wr_status && reg_wdata_in[`DWC_ST_DATA_HIT]) begin
        data_hit_flag_out <= 1'b0;
      end
    end
  end

  // read data stands one cycle only
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 32'h0;
    end else if (reg_rd_in) begin
      unique case (reg_addr_in)
        `DWC_OFS_ADDR_CTRL: reg_rdata_out <= {16'h0, address_watch_control};
        `DWC_OFS_REF_A:     reg_rdata_out <= address_watch_reference_a;
        `DWC_OFS_REF_B:     reg_rdata_out <= address_watch_reference_b;
        `DWC_OFS_ADDR_MASK: reg_rdata_out <= address_watch_mask;
        `DWC_OFS_DATA_CTRL: reg_rdata_out <= {16'h0, data_watch_control};
        `DWC_OFS_DATA_REF:  reg_rdata_out <= data_reference;
        `DWC_OFS_DATA_MASK: reg_rdata_out <= data_mask;
        `DWC_OFS_STATUS:    reg_rdata_out <= {30'h0, data_hit_flag_out,
                                              channel_hit_flag_out};
        default:            reg_rdata_out <= 32'h0;
      endcase
    end else begin
      reg_rdata_out <= 32'h0;
    end
  end
endmodule

// ===== dwc_watch_chk.sv
// concurrent checks on the watch channel ports
`timescale 1ns/1ps
`include "dwc_map.svh"
module dwc_watch_chk (
  input wire logic        clk_in,
  input wire logic        rst_n_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic        reg_wr_in,
  input wire logic        pc_valid_in,
  input wire logic        bus_a_valid_in,
  input wire logic        bus_b_valid_in,
  input wire logic        data_valid_in,
  input wire logic        addr_event_out,
  input wire logic        data_event_out,
  input wire logic        channel_hit_flag_out,
  input wire logic        data_hit_flag_out
);
  logic ctl_wr;
  logic off_q;
  assign ctl_wr = reg_wr_in && reg_addr_in == `DWC_OFS_ADDR_CTRL;
  // armed codes may turn on, only dead codes are off
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      off_q <= 1'b1;
    end else if (ctl_wr) begin
      off_q <= reg_wdata_in[13:10] inside {4'h0, 4'hd, 4'he};
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence pc_on_s;
    ctl_wr && off_q && reg_wdata_in[13:10] == 4'hf && reg_wdata_in[1:0] == 2'h3;
  endsequence
  sequence quiet_s;
    !addr_event_out [*2];
  endsequence
  pc_skip_a: assert property (pc_on_s |=> quiet_s)
    else $error("pc matched right after enable");
  off_quiet_a: assert property (off_q && $past(off_q) |-> !addr_event_out)
    else $error("event while channel off");
  hit_flag_a: assert property (addr_event_out |-> channel_hit_flag_out)
    else $error("address hit flag missing");
  data_flag_a: assert property (data_event_out |-> data_hit_flag_out)
    else $error("data hit flag missing");
  flag_cause_a: assert property ($rose(channel_hit_flag_out) |-> addr_event_out)
    else $error("flag set without event");
  flag_hold_a: assert property ($fell(channel_hit_flag_out) |->
    $past(reg_wr_in && reg_addr_in == `DWC_OFS_STATUS && reg_wdata_in[0]))
    else $error("flag dropped without clear");
  addr_cause_a: assert property (addr_event_out |->
    $past(pc_valid_in || bus_a_valid_in || bus_b_valid_in))
    else $error("address event without access");
  data_cause_a: assert property (data_event_out |-> $past(data_valid_in))
    else $error("data event without access");
endmodule

bind dwc_watch dwc_watch_chk u_chk (.*);

// ===== dwc_core_model.sv
// core bus model: one access per call
`timescale 1ns/1ps
module dwc_core_model (
  input  wire logic         clk_in,
  output logic [31:0]       pc_out,
  output logic              pc_valid_out,
  output logic [31:0]       bus_a_out,
  output logic              bus_a_valid_out,
  output logic              bus_a_write_out,
  output dwc_pkg::dwc_aw_t  bus_a_width_out,
  output logic [31:0]       bus_b_out,
  output logic              bus_b_valid_out,
  output logic              bus_b_write_out,
  output dwc_pkg::dwc_aw_t  bus_b_width_out,
  output logic [63:0]       data_out,
  output logic              data_valid_out,
  output logic              data_write_out,
  output dwc_pkg::dwc_ops_t data_ops_out
);
  import dwc_pkg::*;
  initial begin
    {pc_out, pc_valid_out, bus_a_out, bus_a_valid_out, bus_a_write_out} = '0;
    {bus_b_out, bus_b_valid_out, bus_b_write_out, data_out, data_valid_out, data_write_out} = '0;
    bus_a_width_out = DWC_AW_8;
    bus_b_width_out = DWC_AW_8;
    data_ops_out = DWC_OPS_1;
  end
  // k: 0 pc, 1 bus a, 2 bus b, 3 both buses, 4 data
  task automatic acc(input int k, input logic [63:0] v, input int wr, input int w);
    @(posedge clk_in);
    {pc_out, bus_a_out, bus_b_out} <= {3{v[31:0]}};
    data_out <= v;
    {bus_a_write_out, bus_b_write_out, data_write_out} <= {3{wr[0]}};
    bus_a_width_out <= dwc_aw_t'(w[1:0]);
    bus_b_width_out <= dwc_aw_t'(w[1:0]);
    data_ops_out <= dwc_ops_t'(w[1:0]);
    pc_valid_out <= k == 0;
    bus_a_valid_out <= k == 1 || k == 3;
    bus_b_valid_out <= k == 2 || k == 3;
    data_valid_out <= k == 4;
    @(posedge clk_in);
    {pc_valid_out, bus_a_valid_out, bus_b_valid_out, data_valid_out} <= 4'h0;
    // released lines flip, no stale value
    {pc_out, bus_a_out, bus_b_out} <= {3{~v[31:0]}};
    data_out <= ~v;
  endtask
endmodule

// ===== tb.sv
// self-checking bench of the watch channel
`timescale 1ns/1ps
`include "dwc_map.svh"
module tb;
  import dwc_pkg::*;
  localparam logic [7:0] a_ctl = `DWC_OFS_ADDR_CTRL;
  logic        clk_in = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  ra = 8'h0;
  logic [31:0] wd = 32'h0;
  logic        rwr = 1'b0;
  logic        rrd = 1'b0;
  logic [7:0]  chev = 8'h0;
  logic        cnt = 1'b0;
  logic        pin = 1'b0;
  logic [31:0] rdo, pc, xa, xb;
  logic [63:0] dv;
  logic        pcv, xav, xaw, xbv, xbw, dvv, dvw, aev, dev, af, df;
  dwc_aw_t     xaz, xbz;
  dwc_ops_t    dop;
  int          err_total = 0;
  int          n_checks = 0;

  always #2 clk_in = ~clk_in;

  dwc_core_model core (.clk_in(clk_in), .pc_out(pc), .pc_valid_out(pcv), .bus_a_out(xa),
    .bus_a_valid_out(xav), .bus_a_write_out(xaw), .bus_a_width_out(xaz), .bus_b_out(xb),
    .bus_b_valid_out(xbv), .bus_b_write_out(xbw), .bus_b_width_out(xbz), .data_out(dv),
    .data_valid_out(dvv), .data_write_out(dvw), .data_ops_out(dop));

  dwc_watch dut (.clk_in(clk_in), .rst_n_in(rst_n), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(rwr), .reg_rd_in(rrd), .reg_rdata_out(rdo), .pc_in(pc), .pc_valid_in(pcv),
    .data_address_bus_a_in(xa), .bus_a_valid_in(xav), .bus_a_write_in(xaw),
    .bus_a_width_in(xaz), .data_address_bus_b_in(xb), .bus_b_valid_in(xbv),
    .bus_b_write_in(xbw), .bus_b_width_in(xbz), .data_value_in(dv), .data_valid_in(dvv),
    .data_write_in(dvw), .data_ops_in(dop), .channel_event_in(chev), .count_event_in(cnt),
    .event_pin_in(pin), .data_event_pin_in(1'b0), .event_pin_config_in(1'b1),
    .data_event_pin_config_in(1'b0), .addr_event_out(aev), .data_event_out(dev),
    .channel_hit_flag_out(af), .data_hit_flag_out(df));

  function automatic logic [31:0] actl(int en, int cs, int cb, int ca, int at, int bs);
    return {18'h0, en[3:0], cs[1:0], cb[1:0], ca[1:0], at[1:0], bs[1:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    ra <= a;
    wd <= d;
    rwr <= 1'b1;
    @(posedge clk_in);
    rwr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_in);
    ra <= a;
    rrd <= 1'b1;
    @(posedge clk_in);
    rrd <= 1'b0;
    #1 chk(rdo, exp);
  endtask

  task automatic hit(input int k, input logic [63:0] v, input int w, input int z,
                     input logic e);
    core.acc(k, v, w, z);
    #1 chk(k == 4 ? dev : aev, e);
  endtask

  task automatic t_reset();
    rd(a_ctl, 32'h0);
    rd(`DWC_OFS_ADDR_MASK, 32'hffffffff);
    rd(`DWC_OFS_DATA_CTRL, 32'h0);
    rd(8'h20, 32'h0);
    wr(`DWC_OFS_REF_B, 32'ha5a50f0f);
    rd(`DWC_OFS_REF_B, 32'ha5a50f0f);
    wr(a_ctl, 32'hc000);
    rd(a_ctl, 32'h0);
  endtask

  task automatic t_cond();
    logic [11:0] ex = 12'h32a;
    wr(`DWC_OFS_REF_A, 32'h100);
    wr(`DWC_OFS_REF_B, 32'h100);
    for (int s = 0; s < 2; s++) begin
      for (int c = 0; c < 4; c++) begin
        wr(a_ctl, actl(15, s, s ? c : 0, s ? 0 : c, 0, s));
        for (int i = 0; i < 3; i++) begin
          hit(s + 1, 32'hff + i, 0, 0, ex[3 * c + i]);
        end
      end
    end
    rd(`DWC_OFS_STATUS, 32'h1);
    wr(`DWC_OFS_STATUS, 32'h1);
    rd(`DWC_OFS_STATUS, 32'h0);
  endtask

  task automatic t_ats();
    for (int at = 0; at < 4; at++) begin
      wr(a_ctl, actl(15, 0, 0, 0, at, 0));
      for (int w = 0; w < 2; w++) begin
        hit(1, 32'h100, w, 0, at == 2 || at == w);
      end
    end
  endtask

  // k 0: pc skipped one cycle after bus, k 1: bus match then
  task automatic t_lat(input int k);
    wr(a_ctl, 32'h0);
    fork
      wr(a_ctl, actl(15, 0, 0, 0, 2, k ? 0 : 3));
      begin
        repeat (2) @(posedge clk_in);
        core.acc(k, 32'h100, 0, 0);
      end
    join
    #1 chk(aev, k);
    hit(k, 32'h100, 0, 0, 1'b1);
  endtask

  task automatic t_arm();
    int dead [3] = '{0, 13, 14};
    for (int c = 1; c < 11; c++) begin
      if (c == 9) continue;
      wr(a_ctl, actl(c, 0, 0, 0, 2, 0));
      hit(1, 32'h100, 0, 0, 1'b0);
      @(posedge clk_in);
      chev <= 8'(1 << (c - 1));
      cnt <= c == 10;
      @(posedge clk_in);
      chev <= 8'h0;
      cnt <= 1'b0;
      rd(a_ctl, actl(15, 0, 0, 0, 2, 0));
      hit(1, 32'h100, 0, 0, 1'b1);
      hit(1, 32'h100, 1, 0, 1'b1);
    end
    foreach (dead[i]) begin
      wr(a_ctl, actl(dead[i], 0, 0, 0, 2, 0));
      hit(1, 32'h100, 0, 0, 1'b0);
    end
  endtask

  task automatic t_pin();
    wr(a_ctl, actl(11, 0, 0, 0, 2, 0));
    for (int p = 1; p >= 0; p--) begin
      hit(1, 32'h100, 0, 0, !p);
      @(posedge clk_in);
      pin <= p[0];
      // synchroniser plus rewrite edge
      repeat (4) @(posedge clk_in);
      rd(a_ctl, actl(12 - !p, 0, 0, 0, 2, 0));
    end
    hit(1, 32'h100, 0, 0, 1'b0);
  endtask

  task automatic t_width();
    logic [31:0] ad [5] = '{32'h100, 32'h100, 32'h102, 32'h106, 32'h104};
    wr(a_ctl, actl(15, 0, 0, 0, 2, 0));
    wr(`DWC_OFS_ADDR_MASK, 32'hffffff0f);
    hit(1, 32'h1f0, 0, 0, 1'b1);
    hit(1, 32'h200, 0, 0, 1'b0);
    wr(`DWC_OFS_ADDR_MASK, 32'hffffffff);
    wr(`DWC_OFS_REF_A, 32'h101);
    foreach (ad[i]) begin
      hit(1, ad[i], 0, i == 4 ? 2 : i, i inside {1, 2, 3});
    end
  endtask

  task automatic t_comb();
    wr(`DWC_OFS_REF_A, 32'h300);
    wr(`DWC_OFS_REF_B, 32'h300);
    for (int cs = 2; cs < 4; cs++) begin
      wr(a_ctl, actl(15, cs, 0, 0, 2, 2));
      for (int k = 1; k < 4; k++) begin
        hit(k, 32'h300, 0, 0, cs == 3 || k == 3);
      end
    end
  endtask

  task automatic t_data();
    int aw [9] = '{0, 0, 0, 1, 1, 1, 2, 2, 3};
    int op [9] = '{0, 0, 2, 1, 0, 2, 1, 1, 0};
    logic [31:0] rf [9] = '{32'h5a, 32'h5a, 32'h5a, 32'h1234, 32'h1234, 32'h1234,
                            32'hdeadbeef, 32'hbeef, 32'h5a};
    logic [63:0] v [9] = '{64'h5a, 64'h5a00, 64'h5a0000, 64'h12340000, 64'h12340000,
                           64'h1234000000000000, 64'hdeadbeef00000000,
                           64'h1234beef00000000, 64'h5a};
    foreach (aw[i]) begin
      wr(`DWC_OFS_DATA_CTRL, 32'h0);
      wr(`DWC_OFS_DATA_REF, rf[i]);
      wr(`DWC_OFS_DATA_MASK, i == 7 ? 32'hffff : 32'hffffffff);
      wr(`DWC_OFS_DATA_CTRL, {22'h0, aw[i][1:0], 8'h79});
      hit(4, v[i], 1, op[i], !(i inside {1, 4, 8}));
    end
    rd(`DWC_OFS_STATUS, 32'h3);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    err_total++;
    stop_test();
  end

  initial begin
    repeat (16) @(posedge clk_in);
    rst_n <= 1'b1;
    t_reset();
    t_cond();
    t_ats();
    t_lat(0);
    t_lat(1);
    t_arm();
    t_pin();
    t_width();
    t_comb();
    t_data();
    stop_test();
  end
endmodule
